// File: include/adcc_defs.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define ADCC_OFF_RES_LO 8'h78
`define ADCC_OFF_RES_HI 8'h79
`define ADCC_OFF_CTRL_A 8'h7a
`define ADCC_OFF_CTRL_B 8'h7b
`define ADCC_OFF_MUX 8'h7c
`define ADCC_OFF_DIDR 8'h7e
`define ADCC_BIT_ON 7
`define ADCC_BIT_GO 6
`define ADCC_BIT_AUTO 5
`define ADCC_BIT_FLAG 4
`define ADCC_BIT_IE 3
`define ADCC_BIT_LADJ 5
`define ADCC_RST_BYTE 8'h00
`define ADCC_FIRST_CYC 5'd25
`define ADCC_NORM_CYC 5'd13
`define ADCC_CH_TEMP 4'h8
`define ADCC_CH_BG 4'he
`define ADCC_CH_GND 4'hf
`define ADCC_TS_FREE 3'h0
`endif

// File: include/adcc_pkg.sv
// types shared by the converter control block
package adcc_pkg;
    typedef enum logic [2:0] {
        ADCC_IDLE = 3'b001,
        ADCC_CONV = 3'b010,
        ADCC_DONE = 3'b100
    } adcc_state_t;

    // command to the analogue core
    typedef struct packed {
        logic sample;
        logic first;
        logic [3:0] channel;
        logic [1:0] reference;
    } adcc_core_cmd_t;

    // software register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcc_bus_req_t;
endpackage : adcc_pkg

// File: verilog/adcc_ctrl.sv
// converter control: registers, prescaler, trigger, sequencing and locked result read
`include "adcc_defs.svh"

module adcc_ctrl
    import adcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire adcc_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic global_irq_on,
    input wire logic irq_vector_ack,
    output logic irq_req,
    input wire logic [6:0] trig_flags,
    output adcc_core_cmd_t core_cmd,
    output logic core_clk_en,
    input wire logic [9:0] core_result,
    input wire logic [5:0] pin_in_raw,
    output logic [5:0] pin_in_gated,
    output logic [5:0] pin_buf_off
);

    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    logic [7:0] ctrl_a_r;
    logic [7:0] mux_r;
    logic [2:0] ctrl_b_r;
    logic [5:0] didr_r;
    logic [9:0] result_r;
    logic lock_r;
    logic [9:0] pend_r;
    logic pend_v_r;
    logic first_r;
    logic [3:0] chan_act_r;
    logic [1:0] ref_act_r;
    logic [6:0] pre_cnt_r;
    logic [4:0] cyc_r;
    logic trig_lvl_r;
    adcc_state_t state_r;
    adcc_state_t state_nxt;
    logic [7:0] rdata_r;
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic [5:0] pin_s3_r;
    logic [5:0] pin_stable_r;

    // divisor mask for a prescaler code
    function automatic logic [6:0] adcc_div_mask(input logic [2:0] code);
        case (code)
            3'h0, 3'h1: adcc_div_mask = 7'h01;
            3'h2: adcc_div_mask = 7'h03;
            3'h3: adcc_div_mask = 7'h07;
            3'h4: adcc_div_mask = 7'h0f;
            3'h5: adcc_div_mask = 7'h1f;
            3'h6: adcc_div_mask = 7'h3f;
            default: adcc_div_mask = 7'h7f;
        endcase
    endfunction : adcc_div_mask

    // trigger level for a source code, code 0 gives none
    function automatic logic adcc_trig_sel(input logic [2:0] code, input logic [6:0] flags);
        if (code == `ADCC_TS_FREE) begin
            adcc_trig_sel = 1'b0;
        end else begin
            adcc_trig_sel = flags[code - 3'h1];
        end
    endfunction : adcc_trig_sel

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire wr_a = bus_req.wr && bus_req.addr == `ADCC_OFF_CTRL_A;
    wire wr_b = bus_req.wr && bus_req.addr == `ADCC_OFF_CTRL_B;
    wire wr_m = bus_req.wr && bus_req.addr == `ADCC_OFF_MUX;
    wire wr_d = bus_req.wr && bus_req.addr == `ADCC_OFF_DIDR;
    wire rd_lo = bus_req.rd && bus_req.addr == `ADCC_OFF_RES_LO;
    wire rd_hi = bus_req.rd && bus_req.addr == `ADCC_OFF_RES_HI;
    wire conv_on = ctrl_a_r[`ADCC_BIT_ON];
    wire on_nxt = wr_a ? bus_req.wdata[`ADCC_BIT_ON] : conv_on;
    wire auto_on = ctrl_a_r[`ADCC_BIT_AUTO];
    wire busy = state_r == ADCC_CONV;
    wire adc_tick = conv_on && ((pre_cnt_r & adcc_div_mask(ctrl_a_r[2:0])) == 7'h00);
    wire trig_lvl = adcc_trig_sel(ctrl_b_r, trig_flags);
    wire trig_edge = auto_on && trig_lvl && !trig_lvl_r;
    wire sw_go = wr_a && bus_req.wdata[`ADCC_BIT_GO] && on_nxt;
    wire free_go = auto_on && ctrl_b_r == `ADCC_TS_FREE && state_r == ADCC_DONE;
    wire last_cyc = busy && adc_tick && cyc_r == 5'd1;
    wire start_req = on_nxt && !busy && (sw_go || trig_edge || free_go);
    wire flag_set = last_cyc;
    wire flag_clr = (wr_a && bus_req.wdata[`ADCC_BIT_FLAG]) || irq_vector_ack;
    wire [9:0] shown = result_r;
    wire [7:0] res_lo = mux_r[`ADCC_BIT_LADJ] ? {shown[1:0], 6'h00} : shown[7:0];
    wire [7:0] res_hi = mux_r[`ADCC_BIT_LADJ] ? shown[9:2] : {6'h00, shown[9:8]};
    wire [7:0] ctrl_a_view = {ctrl_a_r[7], busy, ctrl_a_r[5:0]};

    // read data mux, unmapped reads give zero
    wire [7:0] rd_mux = (bus_req.addr == `ADCC_OFF_RES_LO) ? res_lo :
                        (bus_req.addr == `ADCC_OFF_RES_HI) ? res_hi :
                        (bus_req.addr == `ADCC_OFF_CTRL_A) ? ctrl_a_view :
                        (bus_req.addr == `ADCC_OFF_CTRL_B) ? {5'h00, ctrl_b_r} :
                        (bus_req.addr == `ADCC_OFF_MUX) ? {mux_r[7:5], 1'b0, mux_r[3:0]} :
                        (bus_req.addr == `ADCC_OFF_DIDR) ? {2'h0, didr_r} : 8'h00;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ADCC_IDLE: if (start_req) state_nxt = ADCC_CONV;
            ADCC_CONV: if (!on_nxt) state_nxt = ADCC_IDLE;
                       else if (last_cyc) state_nxt = ADCC_DONE;
            ADCC_DONE: if (start_req) state_nxt = ADCC_CONV;
                       else state_nxt = ADCC_IDLE;
            default: state_nxt = ADCC_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ADCC_IDLE;
            cyc_r <= 5'd0;
            first_r <= 1'b1;
            pre_cnt_r <= 7'h00;
            trig_lvl_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            trig_lvl_r <= trig_lvl;
            pre_cnt_r <= conv_on ? pre_cnt_r + 7'h01 : 7'h00;
            if (!on_nxt) begin
                first_r <= 1'b1;
            end else if (state_nxt == ADCC_CONV && !busy) begin
                cyc_r <= first_r ? `ADCC_FIRST_CYC : `ADCC_NORM_CYC;
                first_r <= 1'b0;
            end else if (busy && adc_tick) begin
                cyc_r <= cyc_r - 5'd1;
            end
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_a_r <= `ADCC_RST_BYTE;
            ctrl_b_r <= 3'h0;
            mux_r <= `ADCC_RST_BYTE;
            didr_r <= 6'h00;
        end else begin
            if (wr_a) begin
                ctrl_a_r[7] <= bus_req.wdata[7];
                ctrl_a_r[5] <= bus_req.wdata[5];
                ctrl_a_r[3:0] <= bus_req.wdata[3:0];
            end
            if (flag_set) begin
                ctrl_a_r[`ADCC_BIT_FLAG] <= 1'b1;
            end else if (flag_clr) begin
                ctrl_a_r[`ADCC_BIT_FLAG] <= 1'b0;
            end
            ctrl_a_r[6] <= 1'b0;
            if (wr_b) ctrl_b_r <= bus_req.wdata[2:0];
            if (wr_m) mux_r <= {bus_req.wdata[7:5], 1'b0, bus_req.wdata[3:0]};
            if (wr_d) didr_r <= bus_req.wdata[5:0];
        end
    end

    // ----------------------------------------
    // channel and reference applied only between conversions
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_act_r <= 4'h0;
            ref_act_r <= 2'h0;
        end else if (!busy) begin
            chan_act_r <= mux_r[3:0];
            ref_act_r <= mux_r[7:6];
        end
    end

    // ----------------------------------------
    // result capture with low-then-high lock
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_r <= 10'h000;
            lock_r <= 1'b0;
            pend_r <= 10'h000;
            pend_v_r <= 1'b0;
        end else begin
            if (rd_lo) lock_r <= 1'b1;
            if (rd_hi) lock_r <= 1'b0;
            if (last_cyc && (lock_r || rd_lo)) begin
                pend_r <= core_result;
                pend_v_r <= 1'b1;
            end else if (last_cyc) begin
                result_r <= core_result;
            end else if (pend_v_r && !lock_r) begin
                result_r <= pend_r;
                pend_v_r <= 1'b0;
            end
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= bus_req.rd ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------
    // pin input synchroniser and gating
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_r <= 6'h00;
            pin_s2_r <= 6'h00;
            pin_s3_r <= 6'h00;
            pin_stable_r <= 6'h00;
        end else begin
            pin_s1_r <= pin_in_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_stable_r <= (pin_s2_r & pin_s3_r) | (pin_stable_r & (pin_s2_r | pin_s3_r));
        end
    end

    assign pin_in_gated = pin_stable_r & ~didr_r;
    assign pin_buf_off = didr_r;
    assign rdata = rdata_r;
    assign irq_req = ctrl_a_r[`ADCC_BIT_FLAG] && ctrl_a_r[`ADCC_BIT_IE] && global_irq_on;
    assign core_clk_en = adc_tick;
    assign core_cmd.sample = busy;
    assign core_cmd.first = busy && cyc_r > `ADCC_NORM_CYC;
    assign core_cmd.channel = chan_act_r;
    assign core_cmd.reference = ref_act_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        irq_req == (ctrl_a_r[4] && ctrl_a_r[3] && global_irq_on)) else $error("irq mismatch");
    a_off_aborts: assert property (@(posedge clk) disable iff (rst)
        (busy && wr_a && !bus_req.wdata[7]) |=> state_r == ADCC_IDLE) else $error("no abort");
    a_flag_sets: assert property (@(posedge clk) disable iff (rst)
        last_cyc |=> ctrl_a_r[4]) else $error("flag not set");
    a_chan_hold: assert property (@(posedge clk) disable iff (rst)
        busy && $past(busy) |-> $stable(chan_act_r)) else $error("channel moved");
    a_ref_hold: assert property (@(posedge clk) disable iff (rst)
        busy && $past(busy) |-> $stable(ref_act_r)) else $error("reference moved");
    a_first_len: assert property (@(posedge clk) disable iff (rst)
        (!busy && state_nxt == ADCC_CONV && first_r) |=> cyc_r == 5'd25) else $error("first len");
    a_free_nostart: assert property (@(posedge clk) disable iff (rst)
        (ctrl_b_r == 3'h0) |-> !trig_edge) else $error("free trig");
    a_pin_gate: assert property (@(posedge clk) disable iff (rst)
        (pin_in_gated & didr_r) == 6'h00) else $error("pin not gated");
    a_lock_hold: assert property (@(posedge clk) disable iff (rst)
        (lock_r && !rd_hi) |=> $stable(result_r)) else $error("lock broken");

    // a completion kept during the lock lands once the lock is gone
    a_pend_apply: assert property (@(posedge clk) disable iff (rst)
        (pend_v_r && !lock_r && !last_cyc) |=> result_r == $past(pend_r)) else $error("pending lost");

    // an unlocked completion goes straight into the result
    a_result_load: assert property (@(posedge clk) disable iff (rst)
        (last_cyc && !lock_r && !rd_lo) |=> result_r == $past(core_result)) else $error("result not loaded");

    // start bit view follows the busy state
    a_go_busy: assert property (@(posedge clk) disable iff (rst)
        busy |-> ctrl_a_view[6]) else $error("start bit low while busy");

    // read data are zero unless a read was strobed one cycle before
    a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
        !$past(bus_req.rd) |-> rdata == 8'h00) else $error("stray read data");

    // unused channel mux bit never stores a one
    a_mux_bit4: assert property (@(posedge clk) disable iff (rst)
        mux_r[4] == 1'b0) else $error("mux bit 4 set");

    // left adjusted low byte keeps its six low bits clear
    a_ladj_low: assert property (@(posedge clk) disable iff (rst)
        mux_r[5] |-> res_lo[5:0] == 6'h00) else $error("left low bits");

    // right adjusted high byte keeps its six high bits clear
    a_radj_high: assert property (@(posedge clk) disable iff (rst)
        !mux_r[5] |-> res_hi[7:2] == 6'h00) else $error("right high bits");

    // later conversions load the short count
    a_norm_len: assert property (@(posedge clk) disable iff (rst)
        (!busy && state_nxt == ADCC_CONV && !first_r) |=> cyc_r == 5'd13) else $error("later len");

    // initialisation phase only inside a conversion
    a_core_first: assert property (@(posedge clk) disable iff (rst)
        core_cmd.first |-> core_cmd.sample) else $error("first outside conversion");

    // converter ticks are single pulses, never two in a row
    a_tick_pulse: assert property (@(posedge clk) disable iff (rst)
        core_clk_en |=> !core_clk_en) else $error("tick too long");

    // no converter ticks while switched off
    a_off_quiet: assert property (@(posedge clk) disable iff (rst)
        !conv_on |-> !core_clk_en) else $error("tick while off");

    // software start begins a conversion at the next edge
    a_sw_start: assert property (@(posedge clk) disable iff (rst)
        (sw_go && !busy) |=> busy) else $error("start ignored");

    // a trigger edge begins a conversion when idle and enabled
    a_trig_start: assert property (@(posedge clk) disable iff (rst)
        (trig_edge && on_nxt && !busy) |=> busy) else $error("trigger ignored");

    // without auto trigger no source can start anything
    a_auto_off: assert property (@(posedge clk) disable iff (rst)
        !auto_on |-> !trig_edge) else $error("trigger without auto");

    // free running restarts straight after a completion
    a_free_restart: assert property (@(posedge clk) disable iff (rst)
        (state_r == ADCC_DONE && auto_on && ctrl_b_r == 3'h0 && on_nxt) |=> busy) else $error("no restart");

    // a clear with no completion beside it drops the flag
    a_flag_clear: assert property (@(posedge clk) disable iff (rst)
        (flag_clr && !flag_set) |=> !ctrl_a_r[4]) else $error("flag not cleared");

    // channel follows the register between conversions
    a_chan_apply: assert property (@(posedge clk) disable iff (rst)
        !busy |=> chan_act_r == $past(mux_r[3:0])) else $error("channel not applied");
endmodule : adcc_ctrl

// File: tb/adcc_testbench.sv
// self-checking testbench for the converter control registers
`include "adcc_defs.svh"

module testbench
    import adcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk;
    logic rst;
    adcc_bus_req_t bus_req;
    logic [7:0] rdata;
    logic global_irq_on;
    logic irq_vector_ack;
    logic irq_req;
    logic [6:0] trig_flags;
    adcc_core_cmd_t core_cmd;
    logic core_clk_en;
    logic [9:0] core_result;
    logic [5:0] pin_in_raw;
    logic [5:0] pin_in_gated;
    logic [5:0] pin_buf_off;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int tick_cnt = 0;
    logic conv_seen;
    logic [7:0] d;
    logic [7:0] rst_addrs [7] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7e, 8'h70};
    int n;
    int k;

    adcc_ctrl u_adcc_ctrl (
        .clk(clk),
        .rst(rst),
        .bus_req(bus_req),
        .rdata(rdata),
        .global_irq_on(global_irq_on),
        .irq_vector_ack(irq_vector_ack),
        .irq_req(irq_req),
        .trig_flags(trig_flags),
        .core_cmd(core_cmd),
        .core_clk_en(core_clk_en),
        .core_result(core_result),
        .pin_in_raw(pin_in_raw),
        .pin_in_gated(pin_in_gated),
        .pin_buf_off(pin_buf_off)
    );

    // ----------------------------------------
    // clock, cycle ceiling and tick counting
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // converter ticks seen while a conversion runs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (core_cmd.sample && core_clk_en) tick_cnt <= tick_cnt + 1;
        if (cycles == 30000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, exp});
    endtask : rdc

    // follows one conversion from start to end, bounded by lim cycles
    task automatic wait_done(input int lim);
        conv_seen = 1'b0;
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            if (core_cmd.sample) conv_seen = 1'b1;
            else if (conv_seen) break;
        end
        @(posedge clk);
        #1;
    endtask : wait_done

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        bus_req = '0;
        global_irq_on = 1'b0;
        irq_vector_ack = 1'b0;
        trig_flags = 7'h00;
        core_result = 10'h2a5;
        pin_in_raw = 6'h3f;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // reset values and an unmapped place
        foreach (rst_addrs[i]) rdc(rst_addrs[i], 8'h00);
        wr(`ADCC_OFF_MUX, 8'hff);
        rdc(`ADCC_OFF_MUX, 8'hef);
        wr(`ADCC_OFF_MUX, 8'h03);
        $display("test reset and mux done");
        // first conversion, channel change deferred
        n = tick_cnt;
        wr(`ADCC_OFF_CTRL_A, 8'hc0);
        rdc(`ADCC_OFF_CTRL_A, 8'hc0);
        wr(`ADCC_OFF_MUX, 8'h05);
        chk("channel", {12'h000, core_cmd.channel}, 16'h0003);
        wait_done(3000);
        chk("first ticks", 16'(tick_cnt - n), 16'd25);
        chk("channel", {12'h000, core_cmd.channel}, 16'h0005);
        rdc(`ADCC_OFF_RES_LO, 8'ha5);
        rdc(`ADCC_OFF_RES_HI, 8'h02);
        rdc(`ADCC_OFF_CTRL_A, 8'h90);
        wr(`ADCC_OFF_MUX, 8'h25);
        rdc(`ADCC_OFF_RES_LO, 8'h40);
        rdc(`ADCC_OFF_RES_HI, 8'ha9);
        $display("test conversion done");
        // interrupt request and its clearing by the vector
        global_irq_on <= 1'b1;
        wr(`ADCC_OFF_CTRL_A, 8'h88);
        #1;
        chk("irq on", {15'h0000, irq_req}, 16'h0001);
        @(posedge clk);
        global_irq_on <= 1'b0;
        @(posedge clk);
        #1;
        chk("irq global", {15'h0000, irq_req}, 16'h0000);
        @(posedge clk);
        global_irq_on <= 1'b1;
        irq_vector_ack <= 1'b1;
        @(posedge clk);
        irq_vector_ack <= 1'b0;
        @(posedge clk);
        #1;
        chk("irq ack", {15'h0000, irq_req}, 16'h0000);
        rdc(`ADCC_OFF_CTRL_A, 8'h88);
        // later conversion, write-one clear, locked read
        core_result <= 10'h155;
        n = tick_cnt;
        wr(`ADCC_OFF_CTRL_A, 8'hc8);
        wait_done(3000);
        chk("later ticks", 16'(tick_cnt - n), 16'd13);
        wr(`ADCC_OFF_CTRL_A, 8'h98);
        rdc(`ADCC_OFF_CTRL_A, 8'h88);
        rdc(`ADCC_OFF_RES_HI, 8'h55);
        wr(`ADCC_OFF_MUX, 8'h05);
        rdc(`ADCC_OFF_RES_LO, 8'h55);
        core_result <= 10'h3ff;
        wr(`ADCC_OFF_CTRL_A, 8'hc0);
        wait_done(3000);
        rdc(`ADCC_OFF_RES_HI, 8'h01);
        rdc(`ADCC_OFF_RES_LO, 8'hff);
        rdc(`ADCC_OFF_RES_HI, 8'h03);
        $display("test interrupt and lock done");
        // prescaler: period between converter ticks for every code
        for (int c = 0; c < 8; c++) begin
            wr(`ADCC_OFF_CTRL_A, 8'h90 | 8'(c));
            for (int j = 0; j < 3; j++) begin
                n = 0;
                do begin
                    @(posedge clk);
                    #1;
                    n++;
                end while (!core_clk_en && n < 300);
            end
            chk($sformatf("divider %0d", c), n[15:0], (c == 0) ? 16'd2 : 16'd1 << c);
        end
        // abort by clearing the enable
        wr(`ADCC_OFF_CTRL_A, 8'hc0);
        repeat (4) @(posedge clk);
        wr(`ADCC_OFF_CTRL_A, 8'h00);
        @(posedge clk);
        #1;
        chk("abort", {15'h0000, core_cmd.sample}, 16'h0000);
        rdc(`ADCC_OFF_CTRL_A, 8'h00);
        $display("test prescaler and abort done");
        // auto trigger by a plain edge, then by switching source
        wr(`ADCC_OFF_CTRL_B, 8'h01);
        wr(`ADCC_OFF_CTRL_A, 8'ha0);
        trig_flags <= 7'h01;
        wait_done(3000);
        chk("edge trigger", {15'h0000, conv_seen}, 16'h0001);
        for (k = 1; k < 8; k++) begin
            trig_flags <= 7'h00;
            wr(`ADCC_OFF_CTRL_B, 8'((k % 7) + 1));
            trig_flags <= 7'(1 << (k - 1));
            wait_done(20);
            chk("no trigger", {15'h0000, conv_seen}, 16'h0000);
            wr(`ADCC_OFF_CTRL_B, 8'(k));
            wait_done(3000);
            chk($sformatf("switch %0d", k), {15'h0000, conv_seen}, 16'h0001);
        end
        trig_flags <= 7'h00;
        wr(`ADCC_OFF_CTRL_B, 8'h00);
        wait_done(20);
        chk("free select", {15'h0000, conv_seen}, 16'h0000);
        wr(`ADCC_OFF_CTRL_A, 8'he0);
        wait_done(3000);
        wait_done(3000);
        chk("free restart", {15'h0000, conv_seen}, 16'h0001);
        wr(`ADCC_OFF_CTRL_A, 8'h00);
        $display("test auto trigger done");
        // digital input disable
        wr(`ADCC_OFF_DIDR, 8'h05);
        repeat (5) @(posedge clk);
        #1;
        chk("buf off", {10'h000, pin_buf_off}, 16'h0005);
        chk("gated", {10'h000, pin_in_gated}, 16'h003a);
        rdc(`ADCC_OFF_DIDR, 8'h05);
        $display("test input disable done");
        give_verdict();
    end
endmodule : testbench
